// *** design/sat_auto_test.sv ***
// Top of the automatic scram self-test sequencer
`timescale 1ns/100ps
module sat_auto_test #(
   parameter int PERIOD_CYC = sat_pkg::STEP_CYC,
   parameter int PULSE_CYC = sat_pkg::PULSE_CYC,
   parameter int SAMPLE_CYC = sat_pkg::SETTLE_CYC
) (
   // Clock, reset, enable
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // Operator switches and buttons
   input wire logic i_auto_sel,
   input wire logic i_man_adv_btn,
   input wire logic i_vote_2of3,
   input wire logic i_pulse_pol,
   input wire logic i_unit_replaced,
   input wire logic i_permit_cond,
   // Plant status
   input wire logic i_rate_block,
   input wire logic [1:0] i_logic_trip,
   input wire logic [3:0] i_out_trip,
   // Test pulses
   output logic [2:0] o_level_pulse,
   output logic [1:0] o_rate_pulse,
   output logic [1:0] o_out_direct_pulse,
   // Counter
   output logic [5:0] o_count,
   output logic [5:0] o_count_b,
   // Lamps
   output logic o_lamp_clear,
   output logic o_pulse_lamp_one,
   output logic o_pulse_lamp_two,
   output logic o_pulse_lamp_three,
   output logic o_prog_one_lamp,
   output logic o_prog_two_lamp,
   output logic o_trouble_lamp,
   // Relays and annunciator
   output logic o_no_trouble_relay,
   output logic o_trouble_latch_relay,
   output logic o_annunciator_open,
   output logic o_monitor_ok_relay,
   output logic o_startup_permit_relay
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [12:0] sync1_reg;
   logic [12:0] sync2_reg;
   logic auto_s;
   logic man_s;
   logic vote_s;
   logic pol_s;
   logic repl_s;
   logic cond_s;
   logic rblk_s;
   logic [1:0] ltrip_s;
   logic [3:0] otrip_s;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1_reg <= sat_pkg::SYNC_RST;
         sync2_reg <= sat_pkg::SYNC_RST;
      end else if (i_ce) begin
         sync1_reg <= {i_auto_sel, i_man_adv_btn, i_vote_2of3, i_pulse_pol,
                       i_unit_replaced, i_permit_cond, i_rate_block,
                       i_logic_trip, i_out_trip};
         sync2_reg <= sync1_reg;
      end
   end

   assign {auto_s, man_s, vote_s, pol_s, repl_s, cond_s, rblk_s, ltrip_s, otrip_s} = sync2_reg;

   // ----------------------------------------
   // Button edges
   // ----------------------------------------
   logic man_prev;
   logic repl_prev;
   logic man_edge;
   logic repl_edge;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         man_prev <= 1'b0;
         repl_prev <= 1'b0;
      end else if (i_ce) begin
         man_prev <= man_s;
         repl_prev <= repl_s;
      end
   end

   assign man_edge = man_s && !man_prev;
   assign repl_edge = repl_s && !repl_prev;

   // ----------------------------------------
   // Pacer
   // ----------------------------------------
   logic fire;
   logic win;
   logic sample;
   logic step;

   sat_pacer #(
      .PERIOD_CYC(PERIOD_CYC),
      .PULSE_CYC(PULSE_CYC),
      .SAMPLE_CYC(SAMPLE_CYC)
   ) u_pacer (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .o_fire(fire),
      .o_win(win),
      .o_sample(sample),
      .o_step(step)
   );

   // ----------------------------------------
   // Pattern counter
   // ----------------------------------------
   sat_pkg::sat_mon_t mon_state_reg;
   logic [5:0] count_reg;
   logic [5:0] count_next;
   logic [5:0] count_b_reg;
   logic auto_adv;
   logic man_adv;

   // The trouble latch sits only in the automatic path, so manual stepping
   // still works while a fault is latched
   assign auto_adv = step && auto_s && (mon_state_reg == sat_pkg::MON_OK);
   assign man_adv = !auto_s && man_edge;

   always_comb begin
      count_next = count_reg;
      if (auto_adv || man_adv) begin
         count_next = count_reg + 6'h01;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         count_reg <= sat_pkg::CNT_RST;
         count_b_reg <= ~sat_pkg::CNT_RST;
      end else if (i_ce) begin
         count_reg <= count_next;
         count_b_reg <= ~count_next;
      end
   end

   assign o_count = count_reg;
   assign o_count_b = count_b_reg;

   // ----------------------------------------
   // Pulse gating and routing
   // ----------------------------------------
   logic prog_two;
   logic armed_reg;
   logic live;
   logic [2:0] lvl_next;
   logic [1:0] rate_next;
   logic [1:0] dir_next;
   logic [2:0] lvl_act_reg;
   logic [1:0] rate_act_reg;
   logic [1:0] dir_act_reg;

   assign prog_two = count_reg[sat_pkg::PROG_BIT];

   // The window opens only once the fire gate has launched it
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         armed_reg <= 1'b0;
      end else if (i_ce) begin
         armed_reg <= fire || (armed_reg && win);
      end
   end

   assign live = fire || (armed_reg && win);

   always_comb begin
      lvl_next = 3'h0;
      rate_next = 2'h0;
      dir_next = 2'h0;
      if (live && !prog_two) begin
         lvl_next = ~count_reg[2:0];
      end
      if (live && prog_two && !rblk_s) begin
         rate_next = ~count_reg[1:0];
      end
      if (live && prog_two && rblk_s) begin
         dir_next = ~count_reg[1:0];
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lvl_act_reg <= 3'h0;
         rate_act_reg <= 2'h0;
         dir_act_reg <= 2'h0;
         o_level_pulse <= 3'h0;
         o_rate_pulse <= 2'h0;
         o_out_direct_pulse <= 2'h0;
      end else if (i_ce) begin
         lvl_act_reg <= lvl_next;
         rate_act_reg <= rate_next;
         dir_act_reg <= dir_next;
         // Polarity low gives idle-high pins with low-going pulses
         o_level_pulse <= lvl_next ^ {3{!pol_s}};
         o_rate_pulse <= rate_next ^ {2{!pol_s}};
         o_out_direct_pulse <= dir_next ^ {2{!pol_s}};
      end
   end

   // ----------------------------------------
   // Response check
   // ----------------------------------------
   sat_chk_if u_bus ();
   logic fault_ok_reg;
   logic trouble_set;

   assign u_bus.applied = prog_two ? {1'b0, rate_act_reg | dir_act_reg} : lvl_act_reg;
   assign u_bus.prog_two = prog_two;
   assign u_bus.vote_2of3 = vote_s;
   assign u_bus.logic_trip = ltrip_s;
   assign u_bus.out_trip = otrip_s;

   sat_checker u_checker (
      .bus(u_bus.chk)
   );

   assign trouble_set = sample && u_bus.fault;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fault_ok_reg <= 1'b1;
      end else if (i_ce && sample) begin
         fault_ok_reg <= !u_bus.fault;
      end
   end

   // Set wins over a replacement acknowledge in the same cycle
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mon_state_reg <= sat_pkg::MON_OK;
      end else if (i_ce) begin
         unique case (mon_state_reg)
            sat_pkg::MON_OK: begin
               if (trouble_set) begin
                  mon_state_reg <= sat_pkg::MON_TROUBLE;
               end
            end
            sat_pkg::MON_TROUBLE: begin
               if (repl_edge && !trouble_set) begin
                  mon_state_reg <= sat_pkg::MON_OK;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Relays and lamps
   // ----------------------------------------
   logic monitor_ok_reg;
   logic permit_reg;
   logic lamp_clear_reg;
   logic [2:0] plamp_reg;
   logic prog_one_reg;
   logic prog_two_reg;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         monitor_ok_reg <= 1'b0;
         permit_reg <= 1'b0;
      end else if (i_ce) begin
         monitor_ok_reg <= fault_ok_reg && (mon_state_reg == sat_pkg::MON_OK);
         permit_reg <= monitor_ok_reg && cond_s;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lamp_clear_reg <= 1'b0;
         plamp_reg <= 3'h0;
         prog_one_reg <= 1'b0;
         prog_two_reg <= 1'b0;
      end else if (i_ce) begin
         lamp_clear_reg <= step;
         plamp_reg <= lvl_next | {1'b0, rate_next | dir_next};
         prog_one_reg <= !count_next[sat_pkg::PROG_BIT];
         prog_two_reg <= count_next[sat_pkg::PROG_BIT];
      end
   end

   assign o_lamp_clear = lamp_clear_reg;
   assign {o_pulse_lamp_three, o_pulse_lamp_two, o_pulse_lamp_one} = plamp_reg;
   assign o_prog_one_lamp = prog_one_reg;
   assign o_prog_two_lamp = prog_two_reg;
   assign o_no_trouble_relay = fault_ok_reg;
   assign o_annunciator_open = !fault_ok_reg;
   assign o_trouble_latch_relay = (mon_state_reg == sat_pkg::MON_TROUBLE);
   assign o_trouble_lamp = (mon_state_reg == sat_pkg::MON_TROUBLE);
   assign o_monitor_ok_relay = monitor_ok_reg;
   assign o_startup_permit_relay = permit_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   // Judged from the count at the launching edge, since a manual step may land mid-pulse
   chk_pulse_block_bit: assert property (i_ce && count_reg[0] |=> !lvl_act_reg[0])
      else $error("level pulse fired on a blocked channel");
   chk_auto_step_adv: assert property (i_ce && step && auto_s && !o_trouble_latch_relay
      |=> count_reg == 6'($past(count_reg) + 6'h01))
      else $error("counter missed an automatic step");
   chk_man_hold_count: assert property (i_ce && !auto_s && !man_edge |=> $stable(count_reg))
      else $error("counter moved in manual without button");
   chk_trouble_freeze: assert property (i_ce && auto_s && o_trouble_latch_relay
      |=> $stable(count_reg))
      else $error("counter advanced while trouble latched");
   chk_lamp_clear_step: assert property (i_ce && step |=> o_lamp_clear ##1 (!o_lamp_clear || step))
      else $error("lamp clear did not follow step gate");
   chk_program_route: assert property (prog_two |-> lvl_act_reg == 3'h0)
      else $error("level pulse during program two");
   chk_rate_bypass: assert property (i_ce && rblk_s |=> rate_act_reg == 2'h0)
      else $error("rate unit pulsed while blocked");
   chk_fault_drop_relay: assert property (i_ce && trouble_set
      |=> !o_no_trouble_relay && o_annunciator_open && o_trouble_latch_relay)
      else $error("fault did not drop relay and set latch");
   chk_startup_drop: assert property (o_trouble_latch_relay && i_ce ##1 i_ce
      |=> !o_startup_permit_relay)
      else $error("startup permit held during trouble");
   chk_latch_hold: assert property (o_trouble_latch_relay && !repl_edge |=> o_trouble_latch_relay)
      else $error("trouble latch cleared without replacement");

   cov_trouble_seen: cover property (i_ce && trouble_set);
   cov_count_wrap: cover property (i_ce && count_reg == 6'h3F ##1 count_reg == 6'h00);
   cov_manual_step: cover property (i_ce && man_adv);
   cov_bypass_pulse: cover property (dir_act_reg != 2'h0);
endmodule // sat_auto_test

// *** design/sat_pkg.sv ***
// Shared constants and types of the automatic scram self-test sequencer
package sat_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int PULSE_US = 200;
   localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
   localparam int STEP_US = 2000;
   localparam int STEP_CYC = STEP_US * CLK_MHZ;
   localparam int SETTLE_US = 150;
   localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
   // ----------------------------------------
   // Counter layout and reset values
   // ----------------------------------------
   localparam int CNT_W = 6;
   localparam int PROG_BIT = 3;
   localparam logic [5:0] CNT_RST = 6'h00;
   localparam int SYNC_W = 13;
   localparam logic [12:0] SYNC_RST = 13'h0000;
   typedef enum logic [0:0] {
      MON_OK = 1'b0,
      MON_TROUBLE = 1'b1
   } sat_mon_t;
endpackage

// *** design/sat_chk_if.sv ***
// Bundle between the sequencer and its response checker
`timescale 1ns/100ps
interface sat_chk_if;
   logic [2:0] applied;
   logic prog_two;
   logic vote_2of3;
   logic [1:0] logic_trip;
   logic [3:0] out_trip;
   logic fault;
   modport seq (output applied, prog_two, vote_2of3, logic_trip, out_trip, input fault);
   modport chk (input applied, prog_two, vote_2of3, logic_trip, out_trip, output fault);
endinterface

// *** design/sat_pacer.sv ***
// Pacer: step period, pulse window, sample strobe and step gate
`timescale 1ns/100ps
module sat_pacer #(
   parameter int PERIOD_CYC = sat_pkg::STEP_CYC,
   parameter int PULSE_CYC = sat_pkg::PULSE_CYC,
   parameter int SAMPLE_CYC = sat_pkg::SETTLE_CYC
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // Gates
   output logic o_fire,
   output logic o_win,
   output logic o_sample,
   output logic o_step
);
   localparam int PW = $clog2(PERIOD_CYC + 1);
   logic [PW-1:0] phase_reg;
   logic [PW-1:0] win_len;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         phase_reg <= '0;
      end else if (i_ce) begin
         phase_reg <= (phase_reg == PW'(PERIOD_CYC - 1)) ? '0 : PW'(phase_reg + 1'b1);
      end
   end

   // Gate outputs are decoded from the phase and then registered
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_fire <= 1'b0;
         o_win <= 1'b0;
         o_sample <= 1'b0;
         o_step <= 1'b0;
      end else if (i_ce) begin
         o_fire <= (phase_reg == '0);
         o_win <= (phase_reg < PW'(PULSE_CYC));
         o_sample <= (phase_reg == PW'(SAMPLE_CYC));
         o_step <= (phase_reg == PW'(PERIOD_CYC - 1));
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         win_len <= '0;
      end else if (i_ce) begin
         win_len <= o_win ? PW'(win_len + 1'b1) : '0;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   chk_pulse_width_len: assert property ($fell(o_win) && $past(i_ce) |-> win_len == PW'(PULSE_CYC))
      else $error("test pulse window has wrong width");
   chk_sample_in_window: assert property (o_sample |-> o_win)
      else $error("sample strobe outside pulse window");
endmodule // sat_pacer

// *** design/sat_checker.sv ***
// Response checker: expected trips versus observed trips
`timescale 1ns/100ps
module sat_checker (
   // Checker side of the bundle
   sat_chk_if.chk bus
);
   logic [1:0] n_lvl;
   logic exp_logic;
   logic exp_out;

   always_comb begin
      n_lvl = {1'b0, bus.applied[0]} + {1'b0, bus.applied[1]} + {1'b0, bus.applied[2]};
      // Vote mode follows the operator selection
      exp_logic = bus.vote_2of3 ? (n_lvl >= 2'h2) : (n_lvl != 2'h0);
      exp_out = |bus.applied[1:0];
      // A logic unit in program one, or an output unit in program two, differing from expectation is a malfunction
      bus.fault = bus.prog_two ? (bus.out_trip != {4{exp_out}})
                               : (bus.logic_trip != {2{exp_logic}});
   end
endmodule // sat_checker

// *** bench/sat_plant_model.sv ***
// Behavioural trip units, logic units and output units facing the sequencer
`timescale 1ns/100ps
module sat_plant_model (
   // Pulse pins and operator settings
   input wire logic [2:0] i_level_pulse,
   input wire logic [1:0] i_rate_pulse,
   input wire logic [1:0] i_direct_pulse,
   input wire logic i_pulse_pol,
   input wire logic i_vote_2of3,
   input wire logic i_rate_block,
   input wire logic i_stuck_f,
   // Unit responses
   output logic [1:0] o_logic_trip,
   output logic [3:0] o_out_trip
);
   logic [2:0] lvl;
   logic [1:0] rate;
   logic [1:0] dir;
   logic [1:0] n_lvl;
   logic vote_ok;
   logic bus_a;
   logic bus_b;
   always_comb begin
      lvl = i_pulse_pol ? i_level_pulse : ~i_level_pulse;
      // Blocked rate units ignore their pulses
      rate = (i_pulse_pol ? i_rate_pulse : ~i_rate_pulse) & {2{~i_rate_block}};
      dir = i_pulse_pol ? i_direct_pulse : ~i_direct_pulse;
      n_lvl = 2'(lvl[0]) + 2'(lvl[1]) + 2'(lvl[2]);
      vote_ok = i_vote_2of3 ? (n_lvl >= 2'h2) : (n_lvl != 2'h0);
      // A stuck logic unit shows a trip whatever the pattern
      o_logic_trip = {vote_ok, vote_ok | i_stuck_f};
      bus_a = o_logic_trip[0] | rate[1] | dir[1];
      bus_b = o_logic_trip[1] | rate[0] | dir[0];
      o_out_trip = {4{bus_a | bus_b}};
   end
endmodule // sat_plant_model

// *** bench/scram_auto_test_sequencer_test.sv ***
// Self-checking bench of the automatic scram self-test sequencer
`timescale 1ns/100ps
module scram_auto_test_sequencer_test;
   // Short counts keep each sweep of 64 steps brief
   localparam int PER = 40;
   localparam int PW = 10;
   logic i_mclk, i_rst_b, i_ce, i_auto_sel, i_man_adv_btn, i_vote_2of3, i_pulse_pol;
   logic i_unit_replaced, i_permit_cond, i_rate_block, stuck;
   logic [1:0] i_logic_trip;
   logic [3:0] i_out_trip;
   logic [2:0] o_level_pulse;
   logic [1:0] o_rate_pulse, o_out_direct_pulse;
   logic [5:0] o_count, o_count_b;
   logic o_lamp_clear, o_pulse_lamp_one, o_pulse_lamp_two, o_pulse_lamp_three;
   logic o_prog_one_lamp, o_prog_two_lamp, o_trouble_lamp, o_no_trouble_relay;
   logic o_trouble_latch_relay, o_annunciator_open, o_monitor_ok_relay, o_startup_permit_relay;
   int mismatches = 0;
   int n_tests = 0;

   sat_auto_test #(.PERIOD_CYC(PER), .PULSE_CYC(PW), .SAMPLE_CYC(6)) dut (
      .i_mclk, .i_rst_b, .i_ce, .i_auto_sel, .i_man_adv_btn, .i_vote_2of3, .i_pulse_pol,
      .i_unit_replaced, .i_permit_cond, .i_rate_block, .i_logic_trip, .i_out_trip,
      .o_level_pulse, .o_rate_pulse, .o_out_direct_pulse, .o_count, .o_count_b,
      .o_lamp_clear, .o_pulse_lamp_one, .o_pulse_lamp_two, .o_pulse_lamp_three,
      .o_prog_one_lamp, .o_prog_two_lamp, .o_trouble_lamp, .o_no_trouble_relay,
      .o_trouble_latch_relay, .o_annunciator_open, .o_monitor_ok_relay,
      .o_startup_permit_relay);

   sat_plant_model plant (
      .i_level_pulse(o_level_pulse), .i_rate_pulse(o_rate_pulse),
      .i_direct_pulse(o_out_direct_pulse), .i_pulse_pol, .i_vote_2of3, .i_rate_block,
      .i_stuck_f(stuck), .o_logic_trip(i_logic_trip), .o_out_trip(i_out_trip));

   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_mclk);
   endtask

   task automatic wait_step(input int lim, output logic ok);
      logic [5:0] c;
      c = o_count;
      ok = 1'b0;
      for (int i = 0; i < lim && !ok; i++) begin
         cyc(1);
         ok = (o_count !== c);
      end
   endtask

   task automatic do_reset(input logic vote, input logic pol, input logic rb);
      i_rst_b = 1'b0;
      i_vote_2of3 = vote;
      i_pulse_pol = pol;
      i_rate_block = rb;
      cyc(4);
      check(o_count, 8'h00, "reset count");
      check(o_count_b, 8'h3F, "reset count_b");
      check(o_no_trouble_relay, 8'h01, "reset no_trouble");
      check(o_trouble_lamp, 8'h00, "reset trouble lamp");
      check(o_startup_permit_relay, 8'h00, "reset permit");
      i_rst_b = 1'b1;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Full 64-step auto sweep; pulses seen in each step are judged at the next advance
   task automatic sweep(input logic vote, input logic pol, input logic rb);
      logic [5:0] c, nc;
      logic [2:0] sl, sp, el, al;
      logic [1:0] sr, sd, er, ed, ar, ad;
      logic [7:0] w;
      logic ok;
      int k;
      do_reset(vote, pol, rb);
      wait_step(2 * PER, ok);
      c = o_count;
      {sl, sp, sr, sd, w} = '0;
      for (int n = 0; n < 64; n++) begin
         k = 0;
         while (o_count === c && k < 2 * PER) begin
            al = pol ? o_level_pulse : ~o_level_pulse;
            ar = pol ? o_rate_pulse : ~o_rate_pulse;
            ad = pol ? o_out_direct_pulse : ~o_out_direct_pulse;
            sl |= al;
            sr |= ar;
            sd |= ad;
            sp |= {o_pulse_lamp_three, o_pulse_lamp_two, o_pulse_lamp_one};
            if ({al, ar, ad} != 7'h00) w++;
            cyc(1);
            k++;
         end
         nc = c + 6'h01;
         el = c[3] ? 3'h0 : ~c[2:0];
         er = (c[3] & ~rb) ? ~c[1:0] : 2'h0;
         ed = (c[3] & rb) ? ~c[1:0] : 2'h0;
         check(sl, el, "level pulses");
         check(sr, er, "rate pulses");
         check(sd, ed, "direct pulses");
         check(sp, el | {1'b0, er | ed}, "pulse lamps");
         check(w, ({el, er, ed} != 7'h00) ? 8'(PW) : 8'h00, "pulse width");
         check(o_count, nc, "advance");
         check(o_count_b, 6'(~nc), "count_b");
         check(o_lamp_clear, 8'h01, "lamp clear");
         check({o_prog_two_lamp, o_prog_one_lamp}, nc[3] ? 8'h02 : 8'h01, "prog lamps");
         check(o_no_trouble_relay, 8'h01, "healthy");
         c = nc;
         {sl, sp, sr, sd, w} = '0;
      end
      $display("sweep vote %0b pol %0b block %0b done", vote, pol, rb);
   endtask

   task automatic fault_run();
      logic [5:0] c;
      logic ok;
      do_reset(1'b1, 1'b1, 1'b0);
      cyc(8);
      check(o_monitor_ok_relay, 8'h01, "monitor ok");
      check(o_startup_permit_relay, 8'h01, "permit");
      stuck = 1'b1;
      for (int i = 0; i < 10 * PER && o_no_trouble_relay === 1'b1; i++) cyc(1);
      check(o_no_trouble_relay, 8'h00, "fault seen");
      check(o_annunciator_open, 8'h01, "annunciator");
      check(o_trouble_latch_relay, 8'h01, "latch");
      check(o_trouble_lamp, 8'h01, "trouble lamp");
      cyc(3);
      check(o_monitor_ok_relay, 8'h00, "monitor drop");
      check(o_startup_permit_relay, 8'h00, "permit drop");
      c = o_count;
      cyc(3 * PER);
      check(o_count, c, "frozen");
      check(o_no_trouble_relay, 8'h00, "repeat alarm");
      stuck = 1'b0;
      i_unit_replaced = 1'b1;
      cyc(5);
      i_unit_replaced = 1'b0;
      wait_step(2 * PER, ok);
      check(ok, 8'h01, "resumed");
      check(o_trouble_lamp, 8'h00, "lamp off");
      cyc(PER);
      check(o_no_trouble_relay, 8'h01, "healthy again");
      check(o_startup_permit_relay, 8'h01, "permit back");
      $display("fault run done");
   endtask

   task automatic manual_run();
      logic [5:0] c;
      logic ok;
      i_auto_sel = 1'b0;
      cyc(4);
      c = o_count;
      cyc(3 * PER);
      check(o_count, c, "no auto in manual");
      i_man_adv_btn = 1'b1;
      cyc(4);
      i_man_adv_btn = 1'b0;
      cyc(4);
      check(o_count, 6'(c + 6'h01), "button advance");
      i_auto_sel = 1'b1;
      cyc(4);
      // Clock enable low must freeze the automatic stepping
      i_ce = 1'b0;
      c = o_count;
      cyc(3 * PER);
      check(o_count, c, "frozen by enable");
      i_ce = 1'b1;
      wait_step(2 * PER, ok);
      check(ok, 8'h01, "runs after enable");
      $display("manual run done");
   endtask

   initial begin
      i_ce = 1'b1;
      i_auto_sel = 1'b1;
      i_man_adv_btn = 1'b0;
      i_unit_replaced = 1'b0;
      i_permit_cond = 1'b1;
      stuck = 1'b0;
      sweep(1'b1, 1'b1, 1'b0);
      sweep(1'b0, 1'b0, 1'b1);
      fault_run();
      manual_run();
      summarize();
   end

   // Hang guard, about three times the expected run
   initial begin
      repeat (20000) @(posedge i_mclk);
      mismatches++;
      $display("BAD %0t watchdog expired", $time);
      summarize();
   end
endmodule // scram_auto_test_sequencer_test
